// ==== shared/fmw_pkg.sv ====
/*
 * Constants, types and lookup functions of the fault mode and wake control block.
 * Assumes a 100 MHz register clock and an APB master with 32-bit data.
 */
package fmw_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_NS      = 10;                        // Clock period in ns
   localparam int TICK_US     = 100;                       // Timer base tick
   localparam int TICK_CYC    = TICK_US * 1000 / CLK_NS;
   localparam int RST_DLY_US  = 10;                        // Restart hold time
   localparam int RST_DLY_CYC = RST_DLY_US * 1000 / CLK_NS;
   localparam int IRQ_US      = 100;                       // Interrupt low pulse
   localparam int IRQ_CYC     = IRQ_US * 1000 / CLK_NS;

   // ------------------------------------------------------------
   // Register map and fields
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_TMR0 = 8'h04;
   localparam logic [7:0] OFS_TMR1 = 8'h08;
   localparam logic [7:0] OFS_MAP  = 8'h0C;
   localparam logic [7:0] OFS_STAT = 8'h10;

   localparam int MODE_REQ_LSB  = 0;   // Mode request code, 2 bits
   localparam int OV_FS_BIT     = 4;   // Overvoltage reaction: 1 fail-safe
   localparam int FO_SEL_BIT    = 5;   // Shared pin used as fail output
   localparam int STATIC_EN_BIT = 6;   // Static sensing of wake inputs
   localparam int TMR_PER_LSB   = 0;   // Period code, 3 bits
   localparam int TMR_ON_LSB    = 4;   // On-time code, 3 bits
   localparam int TMR_LVL_BIT   = 8;   // Off-state level of the output
   localparam int MAP_CW_LSB    = 4;   // Cyclic wake timer select
   localparam int ST_WU_LSB     = 0;   // Wake input flags, 2 bits
   localparam int ST_CW_BIT     = 2;   // Cyclic wake flag
   localparam int ST_DRAIN_MONITOR_WAKE_STATUS_BIT   = 3;   // Drain monitor wake flag
   localparam int ST_CMDF_BIT   = 4;   // Command fault flag
   localparam int ST_FAIL_BIT   = 5;   // Fail-safe was entered
   localparam int ST_LVL_LSB    = 6;   // Wake level status, 2 bits
   localparam int ST_MODE_LSB   = 8;   // Current mode, 3 bits

   localparam logic [6:0] MODE_RST = 7'h00;
   localparam logic [8:0] TMR_RST  = 9'h000;
   localparam logic [5:0] MAP_RST  = 6'h00;

   localparam logic [1:0] REQ_NORMAL = 2'h0;
   localparam logic [1:0] REQ_STOP   = 2'h1;
   localparam logic [1:0] REQ_SLEEP  = 2'h2;
   localparam logic [1:0] SEL_T0     = 2'h1;
   localparam logic [1:0] SEL_T1     = 2'h2;
   localparam logic [2:0] ON_OFF     = 3'h0;
   localparam logic [2:0] ON_BAD     = 3'h6;   // Codes from here up disable

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      FMW_RESTART  = 3'h0,
      FMW_NORMAL   = 3'h1,
      FMW_STOP     = 3'h3,
      FMW_SLEEP    = 3'h2,
      FMW_FAILSAFE = 3'h6
   } fmw_mode_e;

   typedef struct packed {
      logic uv;          // Main regulator undervoltage
      logic wd_fail;     // Watchdog trigger failure
      logic wd_ok;       // Watchdog served correctly
      logic ov;          // Main regulator overvoltage
      logic short_gnd;   // Main regulator shorted to ground
      logic second_thermal_shutdown;        // Second thermal shutdown
   } fmw_fault_s;

   // ------------------------------------------------------------
   // Timer code tables, in ticks
   // ------------------------------------------------------------
   function automatic logic [15:0] fmw_per_ticks(input logic [2:0] code);
      case (code)
         3'h0:    fmw_per_ticks = 16'h000A;
         3'h1:    fmw_per_ticks = 16'h0014;
         3'h2:    fmw_per_ticks = 16'h0032;
         3'h3:    fmw_per_ticks = 16'h0064;
         3'h4:    fmw_per_ticks = 16'h00C8;
         3'h5:    fmw_per_ticks = 16'h01F4;
         3'h6:    fmw_per_ticks = 16'h03E8;
         default: fmw_per_ticks = 16'h07D0;
      endcase
   endfunction

   function automatic logic [15:0] fmw_on_ticks(input logic [2:0] code);
      case (code)
         3'h1:    fmw_on_ticks = 16'h0001;
         3'h2:    fmw_on_ticks = 16'h0003;
         3'h3:    fmw_on_ticks = 16'h000A;
         3'h4:    fmw_on_ticks = 16'h0014;
         3'h5:    fmw_on_ticks = 16'h0032;
         default: fmw_on_ticks = 16'h0000;
      endcase
   endfunction

endpackage

// ==== rtl/fmw_top.sv ====
/*
 * Fault mode and wake control: mode sequencer, two cyclic timers, cyclic
 * sense and cyclic wake, APB register slave.
 * Assumes fault, wake and pin inputs are asynchronous and synchronised here.
 */
`timescale 1ns/1ps

module fmw_top #(
   parameter int TICK_LEN = fmw_pkg::TICK_CYC,
   parameter int IRQ_LEN  = fmw_pkg::IRQ_CYC
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire fmw_pkg::fmw_fault_s faults,
   input  wire logic [1:0]         wake_input,
   input  wire logic               drain_monitor_wake,
   input  wire logic [1:0]         hs_fault,
   output logic      [1:0]         high_side_output,
   output logic                    irq_out_low,
   output logic                    reset_out_low,
   output logic                    regulator_enable,
   input  wire logic               fail_or_wake_in,
   output logic                    fail_or_wake_out,
   output logic                    fail_or_wake_oe
);
   import fmw_pkg::*;

   localparam int RCW = $clog2(RST_DLY_CYC + 1);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [11:0] s1, s2, s3;
   wire  [11:0] raw = {faults, wake_input, drain_monitor_wake, hs_fault, fail_or_wake_in};

   // Two stages, third keeps the previous value for edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1 <= 12'h000;
         s2 <= 12'h000;
         s3 <= 12'h000;
      end else begin
         s1 <= raw;
         s2 <= s1;
         s3 <= s2;
      end
   end

   fmw_fault_s flt, flt_d;
   wire  [1:0] wk_s   = s2[5:4];
   wire  [1:0] wk_d   = s3[5:4];
   wire        drain_monitor_wake_status_ev = s2[3] & ~s3[3];
   wire  [1:0] hsf_ev = s2[2:1] & ~s3[2:1];
   wire        fow_ev = s2[0] ^ s3[0];
   assign flt   = fmw_fault_s'(s2[11:6]);
   assign flt_d = fmw_fault_s'(s3[11:6]);

   // ------------------------------------------------------------
   // Registers and APB slave
   // ------------------------------------------------------------
   fmw_mode_e  mode, next_mode;
   logic [6:0] mode_reg;
   logic [8:0] tmr [2];
   logic [5:0] map_reg;
   logic [5:0] flags, next_flags;
   logic [1:0] wk_lvl;
   logic [31:0] rd_mux;

   wire setup   = psel & ~penable;
   wire acc     = psel & penable & pready;
   wire hit_mode = paddr == OFS_MODE;
   wire hit_t0  = paddr == OFS_TMR0;
   wire hit_t1  = paddr == OFS_TMR1;
   wire hit_map = paddr == OFS_MAP;
   wire hit_st  = paddr == OFS_STAT;
   wire addr_ok = hit_mode | hit_t0 | hit_t1 | hit_map | hit_st;
   wire wr      = acc & pwrite & ~pslverr;
   wire [1:0] wr_tmr = {wr & hit_t1, wr & hit_t0};
   wire req_ev  = wr & hit_mode;
   wire [1:0] req = pwdata[MODE_REQ_LSB +: 2];
   wire ov_fs   = mode_reg[OV_FS_BIT];
   wire fo_sel  = mode_reg[FO_SEL_BIT];
   wire st_en   = mode_reg[STATIC_EN_BIT];
   wire [2:0] w_on = pwdata[TMR_ON_LSB +: 3];
   wire w_bad   = (|wr_tmr) & (w_on != ON_OFF) & (w_on < ON_BAD)
                & (fmw_on_ticks(w_on) > fmw_per_ticks(pwdata[TMR_PER_LSB +: 3]));

   // Read data selection
   always_comb begin
      if (hit_mode)     rd_mux = {25'h0000000, mode_reg};
      else if (hit_t0)  rd_mux = {23'h000000, tmr[0]};
      else if (hit_t1)  rd_mux = {23'h000000, tmr[1]};
      else if (hit_map) rd_mux = {26'h0000000, map_reg};
      else if (hit_st)  rd_mux = {21'h000000, mode, wk_lvl, flags};
      else              rd_mux = 32'h00000000;
   end

   // One wait-free access phase; data latched in setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~addr_ok;
         prdata  <= setup ? rd_mux : 32'h00000000;
      end
   end

   // Configuration registers; a mode write keeps request bits out
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= MODE_RST;
         tmr[0]   <= TMR_RST;
         tmr[1]   <= TMR_RST;
         map_reg  <= MAP_RST;
      end else begin
         if (req_ev) mode_reg <= {pwdata[6:4], 4'h0};
         if (wr_tmr[0]) tmr[0] <= pwdata[8:0];
         if (wr_tmr[1]) tmr[1] <= pwdata[8:0];
         if (wr & hit_map) map_reg <= pwdata[5:0];
      end
   end

   // ------------------------------------------------------------
   // Timers
   // ------------------------------------------------------------
   logic [15:0] tick_cnt;
   wire         tick = tick_cnt == 16'(TICK_LEN - 1);
   logic [1:0]  t_valid, wrap, on_ph, smp;

   // Shared base tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) tick_cnt <= 16'h0000;
      else          tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
   end

   for (genvar t = 0; t < 2; t++) begin : g_tmr
      logic [15:0] cnt;
      wire  [2:0]  on_c = tmr[t][TMR_ON_LSB +: 3];
      wire  [15:0] per  = fmw_per_ticks(tmr[t][TMR_PER_LSB +: 3]);
      wire  [15:0] ont  = fmw_on_ticks(on_c);
      assign t_valid[t] = (on_c != ON_OFF) & (on_c < ON_BAD);
      assign wrap[t]  = t_valid[t] & tick & (cnt == per - 16'h0001);
      assign on_ph[t] = t_valid[t] & (cnt < ont);
      assign smp[t]   = t_valid[t] & tick & (cnt == ont - 16'h0001);

      // Period counter, restarted by any write of its setup
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn)                    cnt <= 16'h0000;
         else if (!t_valid[t] | wr_tmr[t]) cnt <= 16'h0000;
         else if (tick)                   cnt <= wrap[t] ? 16'h0000 : cnt + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // Cyclic sense and static sense per output
   // ------------------------------------------------------------
   logic [1:0] hs_dis, cs_act, cs_ref, wk_evt, cs_smp;
   wire  ns  = (mode == FMW_NORMAL) | (mode == FMW_STOP);
   wire  fsm = mode == FMW_FAILSAFE;

   for (genvar h = 0; h < 2; h++) begin : g_hs
      wire [1:0] m    = map_reg[2*h +: 2];
      wire       tsel = m == SEL_T1;
      wire       hs_on = ((m == SEL_T0) | (m == SEL_T1)) & ~hs_dis[h] & ~fsm;
      assign cs_act[h] = hs_on & t_valid[tsel];
      assign cs_smp[h] = cs_act[h] & smp[tsel];
      wire   st_on   = (st_en & ~cs_act[h]) | fsm;
      assign wk_evt[h] = (cs_smp[h] & (wk_s[h] != cs_ref[h]))
                       | (st_on & (wk_s[h] != wk_d[h]));

      // Output drive, fault latch and sample reference
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            high_side_output[h] <= 1'b0;
            hs_dis[h]           <= 1'b0;
            cs_ref[h]           <= 1'b0;
            wk_lvl[h]           <= 1'b0;
         end else begin
            high_side_output[h] <= hs_on & (on_ph[tsel] | tmr[tsel][TMR_LVL_BIT]);
            if (hsf_ev[h] & (ns | (mode == FMW_SLEEP))) hs_dis[h] <= 1'b1;
            else if (wr & hit_map)                      hs_dis[h] <= 1'b0;
            if (cs_smp[h] | ~cs_act[h]) cs_ref[h] <= wk_s[h];
            if (ns & (cs_smp[h] | ~cs_act[h])) wk_lvl[h] <= wk_s[h];
         end
      end
   end

   // ------------------------------------------------------------
   // Wake collection, flags and interrupt pulse
   // ------------------------------------------------------------
   wire [1:0] cw_sel  = map_reg[MAP_CW_LSB +: 2];
   wire cw_ok  = ((cw_sel == SEL_T0) & t_valid[0]) | ((cw_sel == SEL_T1) & t_valid[1]);
   wire cw_ev  = ((cw_sel == SEL_T0) & wrap[0]) | ((cw_sel == SEL_T1) & wrap[1]);
   wire fow_wk = fow_ev & st_en & ~fo_sel;
   wire any_wake = (|wk_evt) | cw_ev | drain_monitor_wake_status_ev | fow_wk;
   wire have_src = st_en | (|cs_act) | cw_ok;
   wire pend     = (|flags[ST_DRAIN_MONITOR_WAKE_STATUS_BIT:ST_WU_LSB]);
   logic cmd_f;
   logic [$clog2(IRQ_LEN + 1) - 1:0] irq_cnt, next_irq_cnt;

   // Sticky flags, set wins over a one-to-clear write
   always_comb begin
      next_flags = flags;
      if (wr & hit_st) next_flags = flags & ~pwdata[5:0];
      next_flags[ST_WU_LSB +: 2] = next_flags[ST_WU_LSB +: 2] | wk_evt;
      next_flags[ST_CW_BIT]   = next_flags[ST_CW_BIT] | cw_ev;
      next_flags[ST_DRAIN_MONITOR_WAKE_STATUS_BIT] = next_flags[ST_DRAIN_MONITOR_WAKE_STATUS_BIT] | drain_monitor_wake_status_ev;
      next_flags[ST_CMDF_BIT] = next_flags[ST_CMDF_BIT] | w_bad | cmd_f;
      next_flags[ST_FAIL_BIT] = next_flags[ST_FAIL_BIT]
                              | (next_mode == FMW_FAILSAFE);
   end

   // Interrupt pulse retriggered by every wake in normal or stop
   always_comb begin
      if (any_wake & ns)     next_irq_cnt = ($bits(irq_cnt))'(IRQ_LEN);
      else if (irq_cnt != 0) next_irq_cnt = irq_cnt - 1'b1;
      else                   next_irq_cnt = irq_cnt;
   end

   // ------------------------------------------------------------
   // Mode sequencer
   // ------------------------------------------------------------
   logic [1:0]     uv_cnt, wd_cnt;
   logic [RCW-1:0] rst_cnt;
   wire uv_ev  = ns & flt.uv & ~flt_d.uv;
   wire wd_ev  = ns & flt.wd_fail & ~flt_d.wd_fail;
   wire ov_ev  = ns & flt.ov & ~flt_d.ov;
   wire ok_ev  = flt.wd_ok & ~flt_d.wd_ok;
   wire fs_hw  = flt.second_thermal_shutdown | flt.short_gnd;
   wire fs_cond = fs_hw | (ov_ev & ov_fs)
                | (wd_ev & (wd_cnt == 2'h3))
                | (uv_ev & (uv_cnt == 2'h3));
   wire rs_cond = uv_ev | wd_ev | (ov_ev & ~ov_fs);
   wire rst_end = rst_cnt == RCW'(RST_DLY_CYC - 1);
   wire tsd_rel = ~flt.second_thermal_shutdown & flt_d.second_thermal_shutdown;

   // Next mode and refused sleep requests
   always_comb begin
      next_mode = mode;
      cmd_f     = 1'b0;
      case (mode)
         FMW_RESTART: begin
            if (fs_hw)        next_mode = FMW_FAILSAFE;
            else if (rst_end) next_mode = FMW_NORMAL;
         end
         FMW_NORMAL, FMW_STOP: begin
            if (fs_cond)      next_mode = FMW_FAILSAFE;
            else if (rs_cond) next_mode = FMW_RESTART;
            else if (req_ev & (req == REQ_NORMAL)) next_mode = FMW_NORMAL;
            else if (req_ev & (req == REQ_STOP) & (mode == FMW_NORMAL)) next_mode = FMW_STOP;
            else if (req_ev & (req == REQ_SLEEP)) begin
               if (mode == FMW_STOP | ~have_src) begin
                  next_mode = FMW_RESTART;
                  cmd_f     = 1'b1;
               end else if (pend) next_mode = FMW_RESTART;
               else               next_mode = FMW_SLEEP;
            end
         end
         FMW_SLEEP: begin
            if (fs_hw)         next_mode = FMW_FAILSAFE;
            else if (any_wake) next_mode = FMW_RESTART;
         end
         FMW_FAILSAFE: begin
            if (tsd_rel | (any_wake & ~flt.second_thermal_shutdown)) next_mode = FMW_RESTART;
         end
         default: next_mode = FMW_RESTART;
      endcase
   end

   // Mode, counters and registered outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode             <= FMW_RESTART;
         rst_cnt          <= '0;
         uv_cnt           <= 2'h0;
         wd_cnt           <= 2'h0;
         flags            <= 6'h00;
         irq_cnt          <= '0;
         irq_out_low      <= 1'b1;
         reset_out_low    <= 1'b0;
         regulator_enable <= 1'b1;
         fail_or_wake_out <= 1'b1;
         fail_or_wake_oe  <= 1'b0;
      end else begin
         mode    <= next_mode;
         rst_cnt <= (mode == FMW_RESTART && !rst_end) ? rst_cnt + 1'b1 : '0;
         if (uv_ev)                uv_cnt <= uv_cnt + 2'h1;
         else if (ok_ev | fsm)     uv_cnt <= 2'h0;
         if (wd_ev)                wd_cnt <= wd_cnt + 2'h1;
         else if (ok_ev | fsm)     wd_cnt <= 2'h0;
         flags            <= next_flags;
         irq_cnt          <= next_irq_cnt;
         irq_out_low      <= next_irq_cnt == 0;
         reset_out_low    <= ~((next_mode == FMW_RESTART) | (next_mode == FMW_SLEEP));
         regulator_enable <= (next_mode != FMW_SLEEP) & (next_mode != FMW_FAILSAFE);
         fail_or_wake_out <= ~(fo_sel & next_flags[ST_FAIL_BIT]);
         fail_or_wake_oe  <= fo_sel & next_flags[ST_FAIL_BIT];
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence sleep_asked;
      mode == FMW_NORMAL && req_ev && req == REQ_SLEEP && !fs_cond && !rs_cond;
   endsequence

   restart_rst_a: assert property (mode == FMW_RESTART |-> !reset_out_low)
      else $error("reset output high in restart");
   restart_exit_a: assert property (mode == FMW_RESTART && rst_end && !fs_hw
      |=> mode == FMW_NORMAL ##1 reset_out_low)
      else $error("restart did not end in normal");
   uv_restart_a: assert property (uv_ev && !fs_cond |=> mode == FMW_RESTART)
      else $error("undervoltage did not restart");
   wd_restart_a: assert property (wd_ev && !fs_cond |=> mode == FMW_RESTART)
      else $error("watchdog failure did not restart");
   sleep_nosrc_a: assert property (sleep_asked ##0 !have_src
      |=> mode == FMW_RESTART && flags[ST_CMDF_BIT])
      else $error("sleep without source not refused");
   hot_fs_a: assert property (flt.second_thermal_shutdown && !fsm |=> fsm)
      else $error("thermal shutdown missed");
   short_fs_a: assert property (flt.short_gnd && !fsm |=> fsm)
      else $error("regulator short missed");
   ov_sel_a: assert property (ov_ev && !fs_hw
      |=> mode == ($past(ov_fs) ? FMW_FAILSAFE : FMW_RESTART))
      else $error("overvoltage reaction wrong");
   wd_four_a: assert property (wd_ev && wd_cnt == 2'h3 |=> fsm)
      else $error("fourth watchdog failure missed");
   uv_four_a: assert property (uv_ev && uv_cnt == 2'h3 |=> fsm)
      else $error("fourth undervoltage missed");
   fo_pin_a: assert property (fsm && fo_sel |=> fail_or_wake_oe && !fail_or_wake_out)
      else $error("fail output not driven");
   cs_irq_a: assert property ((|wk_evt) && ns |=> !irq_out_low [*2])
      else $error("sense wake gave no interrupt");
   bad_on_a: assert property (w_bad |=> flags[ST_CMDF_BIT])
      else $error("on-time fault not flagged");
   fs_hs_off_a: assert property (fsm |=> high_side_output == 2'b00)
      else $error("high side on in fail-safe");
   pend_sleep_a: assert property (sleep_asked ##0 have_src && pend
      |=> mode == FMW_RESTART ##0 !reset_out_low)
      else $error("sleep with pending flags not refused");
endmodule

// ==== tb/fmw_wake_net.sv ====
/* Wake switch network powered by the high-side outputs.
   Assumes the bench sets the switch states. */
`timescale 1ns/1ps
module fmw_wake_net (
   input  wire logic [1:0] high_side_output,
   input  wire logic [1:0] switch_closed,
   output logic      [1:0] wake_input
);
   // Closed switch pulls low; an unpowered line sits at its pull-down
   assign wake_input = high_side_output & ~switch_closed;
endmodule

// ==== tb/fmw_top_bench.sv ====
/* Self-checking bench of the fault mode and wake control block.
   Assumes fmw_pkg and the wake network model are compiled first. */
`timescale 1ns/1ps
module fmw_top_bench;
   import fmw_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q, seed = 32'h964A;
   fmw_fault_s  faults = '0;
   logic [1:0]  sw = 2'h0, hsf = 2'h0, wk, hs;
   logic        pready, pslverr, e, irq_n, rst_n, fwo, fwoe, reg_en;
   int          num_errors = 0, total_checks = 0, i;

   // Design with short tick and pulse lengths
   fmw_top #(.TICK_LEN(4), .IRQ_LEN(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .faults(faults), .wake_input(wk),
      .drain_monitor_wake(1'h0), .hs_fault(hsf), .high_side_output(hs),
      .irq_out_low(irq_n), .reset_out_low(rst_n), .regulator_enable(reg_en),
      .fail_or_wake_in(1'h1), .fail_or_wake_out(fwo), .fail_or_wake_oe(fwoe));
   fmw_wake_net NET (.high_side_output(hs), .switch_closed(sw), .wake_input(wk));

   always #5 pclk = ~pclk;

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x) begin
         num_errors++;
         $display("Error %0t: got %h want %h", $time, g, x);
      end
   endtask

   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // One APB transfer, held until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) chk(0, 1);
      if (pready !== 1'b1) final_report;
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   // Poll the mode field under a bound
   task automatic wait_mode(input logic [2:0] m);
      int k = 0;
      apb(0, OFS_STAT, 0);
      while (q[10:8] !== m && k < 400) begin
         apb(0, OFS_STAT, 0);
         k++;
      end
      chk(q[10:8], m);
      if (q[10:8] !== m) final_report;
   endtask

   // Pulse a fault, expect restart, then normal again
   task automatic fault_restart(input fmw_fault_s f);
      faults <= f;
      repeat (5) @(posedge pclk);
      faults <= '0;
      apb(0, OFS_STAT, 0);
      chk(q[10:8], FMW_RESTART);
      wait_mode(FMW_NORMAL);
   endtask

   // Main sequence
   initial begin
      seed = xs(seed);
      repeat (3) @(posedge pclk);
      chk(rst_n, 0);
      presetn <= 1;
      repeat (400) @(posedge pclk);
      apb(0, OFS_STAT, 0);
      chk(q[10:8], FMW_RESTART);
      chk(rst_n, 0);
      wait_mode(FMW_NORMAL);
      chk(rst_n, 1);
      apb(1, {1'h1, seed[4:0], 2'h0}, seed);
      chk(e, 1);
      apb(1, OFS_MODE, {30'h0, REQ_SLEEP});
      apb(0, OFS_STAT, 0);
      chk(q[10:8], FMW_RESTART);
      chk(q[ST_CMDF_BIT], 1);
      wait_mode(FMW_NORMAL);
      apb(1, OFS_STAT, 32'h3F);
      apb(1, OFS_TMR1, 32'h50);
      apb(0, OFS_STAT, 0);
      chk(q[ST_CMDF_BIT], 1);
      apb(1, OFS_TMR1, 32'h0);
      fault_restart(6'h20);
      fault_restart(6'h10);
      fault_restart(6'h04);
      apb(1, OFS_TMR0, 32'h100);
      apb(1, OFS_MAP, {30'h0, SEL_T0});
      for (i = 0; i < 100 && hs[0] !== 1'b1; i++) @(negedge pclk);
      chk(hs[0], 1);
      apb(1, OFS_TMR0, 32'h110);
      repeat (100) @(posedge pclk);
      apb(0, OFS_STAT, 0);
      chk(q[ST_WU_LSB], 0);
      sw <= 2'h1;
      for (i = 0; i < 100 && irq_n !== 1'b0; i++) @(negedge pclk);
      chk(irq_n, 0);
      apb(0, OFS_STAT, 0);
      chk(q[ST_WU_LSB], 1);
      apb(1, OFS_MODE, {30'h0, REQ_SLEEP});
      apb(0, OFS_STAT, 0);
      chk(q[10:8], FMW_RESTART);
      chk(rst_n, 0);
      wait_mode(FMW_NORMAL);
      hsf <= 2'h1;
      repeat (6) @(posedge pclk);
      chk(hs[0], 0);
      apb(1, OFS_MAP, {30'h0, SEL_T0});
      apb(1, OFS_MODE, 32'h20);
      faults <= 6'h01;
      wait_mode(FMW_FAILSAFE);
      chk(hs, 0);
      chk({fwoe, fwo}, 2'h2);
      chk(reg_en, 0);
      final_report;
   end
endmodule
